/* core/op_mode_pkg.sv */
/*
 package for the operating mode control block: register map,
 field layout, reset values, mode codes, timing and carrier types.
 assumes a 50 MHz mclk and an APB master with 32-bit data.
*/
package op_mode_pkg;

    localparam int ADDR_W = 12;

    localparam logic [ADDR_W-1:0] OFF_MODE_CTL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h004;

    localparam int BIT_SPSEL   = 7;
    localparam int BIT_MODEHI  = 6;
    localparam int BIT_MODELO  = 5;
    localparam int BIT_STRETCH = 4;
    localparam int BIT_VISIBLE = 3;
    localparam int BIT_WAITOFF = 2;
    localparam int BIT_EXPEMU  = 1;
    localparam int BIT_CTLEMU  = 0;

    // mode code is {specialModeSelectN, modeSelectHi, modeSelectLo}
    localparam logic [2:0] MODE_SPC_SINGLE = 3'h0;
    localparam logic [2:0] MODE_SPC_NARROW = 3'h1;
    localparam logic [2:0] MODE_PERIPHERAL = 3'h2;
    localparam logic [2:0] MODE_RESERVED   = 3'h6;
    localparam logic [1:0] SEL_FORBIDDEN   = 2'h2;

    localparam logic RST_STRETCH = 1'b1;
    localparam logic RST_WAITOFF = 1'b0;

    localparam logic [15:0] DBG_ROM_LO = 16'hff20;
    localparam logic [15:0] DBG_REG_LO = 16'hff00;
    localparam logic [15:0] DBG_REG_HI = 16'hff06;
    localparam logic [15:0] TOP_LO     = 16'hff00;
    localparam logic [15:0] TOP_HI     = 16'hffff;

    localparam int CLK_PERIOD_NS = 20;
    localparam int WAIT_DELAY_NS = 80;
    localparam int WAIT_DELAY_CYC =
        (WAIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic specialModeSelectN;
        logic modeSelectHi;
        logic modeSelectLo;
        logic busClockStretchEn;
        logic internalVisibility;
        logic extBusStopInWait;
        logic emulateExpansionPort;
        logic emulateControlPort;
    } mode_ctl_type;

    typedef struct packed {
        logic debugPin;
        logic modeSelectHi;
        logic modeSelectLo;
    } strap_pins_type;

    typedef enum logic [1:0] {
        STRAP_SYNC0 = 2'b00,
        STRAP_SYNC1 = 2'b01,
        STRAP_LOAD  = 2'b10,
        STRAP_DONE  = 2'b11
    } strap_state_type;

endpackage

/* core/operating_mode_control.sv */
/*
 operating mode control: mode register behind an APB slave, strap
 capture, bus clock stretch, visibility, wait shutdown, port
 emulation map gating and background debug overlay decode.
 assumes strap pins are asynchronous, all other inputs on mclk.
*/
// Contract
// (RL1) mode bits capture debug and mode pins
// (RL2) peripheral mode hides the mode register
// (RL3) special select bit: write while zero, skip first
// (RL4) mode select bits: once, or anytime skip first
// (RL5) never select peripheral or reserved mode
// (RL6) expanded modes force stretch enable to one
// (RL7) stretch off frees clock, on follows accesses
// (RL8) stretch bit: once normal, anytime special
// (RL9) visibility drives internal bus cycles out
// (RL10) special narrow visibility shows full width
// (RL11) single chip modes give no visibility
// (RL12) visibility and emulation: once or skip first
// (RL13) wait stop shuts bus after activity ends
// (RL14) wait stop bit writable only in normal
// (RL15) expansion emulation unmaps its port registers
// (RL16) otherwise expansion port stays mapped as GPIO
// (RL17) control emulation unmaps port in expanded
// (RL18) special single chip starts debug active
// (RL19) enabled debug activates on command or instruction
// (RL20) debug maps ROM on top, registers below
// (RL21) debug ROM replaces vectors, hides top page
// (RL22) host avoids debug in peripheral mode
// (RL23) reset values depend on special or normal
`timescale 1ns/1ps
`default_nettype none

module operating_mode_control
    import op_mode_pkg::*;
#(
    parameter int WAIT_DELAY = op_mode_pkg::WAIT_DELAY_CYC
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          clkEn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [op_mode_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire op_mode_pkg::strap_pins_type   strapPins,
    input  wire logic                          extAccess,
    input  wire logic                          intAccess,
    input  wire logic                          waitMode,
    input  wire logic                          busBusy,
    input  wire logic                          debugEnable,
    input  wire logic                          serialDebugCmd,
    input  wire logic                          enterDebugInstr,
    input  wire logic                          debugExit,
    input  wire logic                          serialAccess,
    input  wire logic [15:0]                   cpuAddr,
    output op_mode_pkg::mode_ctl_type          modeCtl,
    output logic                               busClock,
    output logic                               visibleDrive,
    output logic                               wideVisible,
    output logic                               extBusShutdown,
    output logic                               expPortMapped,
    output logic                               expansionEmuEn,
    output logic                               ctlPortMapped,
    output logic                               debugActive,
    output logic                               debugRomSel,
    output logic                               debugRegSel,
    output logic                               userTopHidden
);
    import op_mode_pkg::*;

    function automatic logic inRange(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    // pins pass two flops; first stage feeds only the second
    strap_pins_type strapMeta_reg;
    strap_pins_type strapSync_reg;
    strap_state_type strap_reg;
    strap_state_type strap_next;

    mode_ctl_type modeCtl_reg;
    mode_ctl_type modeCtl_next;
    logic regWritten_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic busClock_reg;
    logic visibleDrive_reg;
    logic wideVisible_reg;
    logic shutdown_reg;
    logic [7:0] waitCnt_reg;
    logic expPortMapped_reg;
    logic expEmuEn_reg;
    logic ctlPortMapped_reg;
    logic debugActive_reg;
    logic debugRomSel_reg;
    logic debugRegSel_reg;
    logic userTopHidden_reg;

    wire logic [2:0] modeCode = {modeCtl_reg.specialModeSelectN,
                                 modeCtl_reg.modeSelectHi,
                                 modeCtl_reg.modeSelectLo};
    wire logic strapDone   = (strap_reg == STRAP_DONE);
    wire logic strapLoad   = (strap_reg == STRAP_LOAD);
    wire logic special     = !modeCtl_reg.specialModeSelectN;
    wire logic peripheral  = (modeCode == MODE_PERIPHERAL);
    wire logic singleChip  = !modeCtl_reg.modeSelectHi
                             && !modeCtl_reg.modeSelectLo;
    wire logic expanded    = modeCtl_reg.modeSelectLo;
    wire logic visEff      = modeCtl_reg.internalVisibility
                             && !singleChip; // (RL11)

    // strap capture, reserved code forced to peripheral
    wire logic [2:0] strapCode = {strapSync_reg.debugPin,
                                  strapSync_reg.modeSelectHi,
                                  strapSync_reg.modeSelectLo};
    wire logic [2:0] bootCode = (strapCode == MODE_RESERVED)
                                ? MODE_PERIPHERAL : strapCode;
    wire logic bootSpecial = !bootCode[2];

    // APB: answer in the second access cycle
    wire logic access     = psel && penable && clkEn;
    wire logic taken      = access && pready_reg;
    wire logic hitMode    = (paddr == OFF_MODE_CTL);
    wire logic hitStatus  = (paddr == OFF_STATUS);
    wire logic modeMapped = hitMode && !peripheral; // (RL2)
    wire logic mapped     = modeMapped || hitStatus;
    wire logic wr         = taken && pwrite && modeMapped
                            && pstrb[0] && strapDone;
    wire logic first      = !regWritten_reg;
    wire logic [7:0] wd   = pwdata[7:0];
    wire logic selOk      = wd[BIT_MODEHI:BIT_MODELO] != SEL_FORBIDDEN;

    wire logic spSelWr = wr && special && !first; // (RL3)
    wire logic selWr   = wr && selOk // (RL5)
                         && (special ? !first : first); // (RL4)
    wire logic strWr   = wr && (special || first); // (RL8)
    wire logic grpWr   = wr && (special ? !first : first); // (RL12)
    wire logic ebWr    = wr && !special; // (RL14)

    wire logic [31:0] readWord =
        hitMode ? {24'h00_0000, modeCtl_reg} :
        {29'h0000_0000, debugActive_reg, shutdown_reg, regWritten_reg};

    always_comb begin
        modeCtl_next = modeCtl_reg;
        if (strapLoad) begin
            modeCtl_next.specialModeSelectN   = bootCode[2]; // (RL1)
            modeCtl_next.modeSelectHi         = bootCode[1];
            modeCtl_next.modeSelectLo         = bootCode[0];
            modeCtl_next.busClockStretchEn    = RST_STRETCH; // (RL23)
            modeCtl_next.extBusStopInWait     = RST_WAITOFF;
            modeCtl_next.internalVisibility   = bootSpecial;
            modeCtl_next.emulateExpansionPort = bootSpecial;
            modeCtl_next.emulateControlPort   = bootSpecial;
        end else begin
            if (spSelWr) begin
                modeCtl_next.specialModeSelectN = wd[BIT_SPSEL];
            end
            if (selWr) begin
                modeCtl_next.modeSelectHi = wd[BIT_MODEHI];
                modeCtl_next.modeSelectLo = wd[BIT_MODELO];
            end
            if (strWr) begin
                modeCtl_next.busClockStretchEn = wd[BIT_STRETCH];
            end
            if (grpWr) begin
                modeCtl_next.internalVisibility   = wd[BIT_VISIBLE];
                modeCtl_next.emulateExpansionPort = wd[BIT_EXPEMU];
                modeCtl_next.emulateControlPort   = wd[BIT_CTLEMU];
            end
            if (ebWr) begin
                modeCtl_next.extBusStopInWait = wd[BIT_WAITOFF];
            end
        end
        // demultiplexing needs stretched cycles
        if (modeCtl_next.modeSelectLo) begin
            modeCtl_next.busClockStretchEn = 1'b1; // (RL6)
        end
    end

    always_comb begin
        case (strap_reg)
            STRAP_SYNC0: strap_next = STRAP_SYNC1;
            STRAP_SYNC1: strap_next = STRAP_LOAD;
            STRAP_LOAD:  strap_next = STRAP_DONE;
            default:     strap_next = STRAP_DONE;
        endcase
    end

    // stretched clock: high on external, low on hidden internal
    wire logic busClockNext =
        !modeCtl_reg.busClockStretchEn ? !busClock_reg : // (RL7)
        extAccess                      ? 1'b1 :
        (intAccess && !visEff)         ? 1'b0 :
        !busClock_reg;

    // shutdown waits for the bus to go idle, then a fixed delay
    wire logic waitArm = waitMode && modeCtl_reg.extBusStopInWait
                         && !busBusy;
    wire logic waitDone = (waitCnt_reg >= 8'(WAIT_DELAY));

    wire logic debugStart = debugEnable
                            && (serialDebugCmd || enterDebugInstr); // (RL19)
    wire logic debugActiveNext =
        strapLoad       ? (bootCode == MODE_SPC_SINGLE) : // (RL18)
        debugActive_reg ? !debugExit : debugStart;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            strapMeta_reg <= '0;
            strapSync_reg <= '0;
            strap_reg     <= STRAP_SYNC0;
        end else if (clkEn) begin
            strapMeta_reg <= strapPins;
            strapSync_reg <= strapMeta_reg;
            strap_reg     <= strap_next;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeCtl_reg    <= '0;
            regWritten_reg <= 1'b0;
        end else if (clkEn) begin
            modeCtl_reg    <= modeCtl_next;
            regWritten_reg <= regWritten_reg || wr;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else if (clkEn) begin
            pready_reg  <= access && !pready_reg;
            pslverr_reg <= access && !pready_reg && !mapped;
            prdata_reg  <= (access && !pready_reg && mapped && !pwrite)
                           ? readWord : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busClock_reg     <= 1'b0;
            visibleDrive_reg <= 1'b0;
            wideVisible_reg  <= 1'b0;
        end else if (clkEn) begin
            busClock_reg     <= strapDone && busClockNext;
            visibleDrive_reg <= visEff && intAccess; // (RL9)
            wideVisible_reg  <= visEff && intAccess
                                && (modeCode == MODE_SPC_NARROW); // (RL10)
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            waitCnt_reg  <= '0;
            shutdown_reg <= 1'b0;
        end else if (clkEn) begin
            if (!waitArm) begin
                waitCnt_reg <= '0;
            end else if (!waitDone) begin
                waitCnt_reg <= waitCnt_reg + 8'h01;
            end
            shutdown_reg <= waitArm && waitDone; // (RL13)
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            expPortMapped_reg <= 1'b1;
            ctlPortMapped_reg <= 1'b1;
            expEmuEn_reg      <= 1'b0;
        end else if (clkEn) begin
            expEmuEn_reg      <= modeCtl_reg.emulateExpansionPort && !singleChip; // (RL16)
            expPortMapped_reg <= !(modeCtl_reg.emulateExpansionPort
                                   && !singleChip); // (RL15) (RL16)
            ctlPortMapped_reg <= !(modeCtl_reg.emulateControlPort
                                   && expanded); // (RL17)
        end
    end

    // host keeps debug out of peripheral mode, no guard here (RL22)
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            debugActive_reg   <= 1'b0;
            debugRomSel_reg   <= 1'b0;
            debugRegSel_reg   <= 1'b0;
            userTopHidden_reg <= 1'b0;
        end else if (clkEn) begin
            debugActive_reg   <= debugActiveNext;
            debugRomSel_reg   <= debugActive_reg
                && inRange(cpuAddr, DBG_ROM_LO, TOP_HI); // (RL20)
            debugRegSel_reg   <= debugActive_reg
                && inRange(cpuAddr, DBG_REG_LO, DBG_REG_HI);
            userTopHidden_reg <= debugActive_reg && !serialAccess
                && inRange(cpuAddr, TOP_LO, TOP_HI); // (RL21)
        end
    end

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign modeCtl        = modeCtl_reg;
    assign busClock       = busClock_reg;
    assign visibleDrive   = visibleDrive_reg;
    assign wideVisible    = wideVisible_reg;
    assign extBusShutdown = shutdown_reg;
    assign expPortMapped  = expPortMapped_reg;
    assign expansionEmuEn = expEmuEn_reg;
    assign ctlPortMapped  = ctlPortMapped_reg;
    assign debugActive    = debugActive_reg;
    assign debugRomSel    = debugRomSel_reg;
    assign debugRegSel    = debugRegSel_reg;
    assign userTopHidden  = userTopHidden_reg;

    sequence waitHeld;
        (waitArm && clkEn) [*4];
    endsequence

    a_strap_capture: assert property (@(posedge mclk) disable iff (rst) // (RL1)
        strapLoad && clkEn |=> modeCode == $past(bootCode))
        else $error("mode bits differ from captured pins");

    a_periph_unmapped: assert property (@(posedge mclk) disable iff (rst) // (RL2)
        access && !pready_reg && hitMode && peripheral |=> pslverr)
        else $error("mode register answered in peripheral mode");

    a_spsel_locked: assert property (@(posedge mclk) disable iff (rst) // (RL3)
        strapDone && modeCtl_reg.specialModeSelectN
        |=> modeCtl_reg.specialModeSelectN)
        else $error("special select bit cleared after set");

    a_no_forbidden_sel: assert property (@(posedge mclk) disable iff (rst) // (RL5)
        strapDone && modeCtl_reg[BIT_MODEHI:BIT_MODELO] != SEL_FORBIDDEN
        |=> modeCtl_reg[BIT_MODEHI:BIT_MODELO] != SEL_FORBIDDEN)
        else $error("peripheral or reserved mode selected");

    a_stretch_expanded: assert property (@(posedge mclk) disable iff (rst) // (RL6)
        strapDone && expanded |-> modeCtl_reg.busClockStretchEn)
        else $error("stretch disabled in expanded mode");

    a_clock_free: assert property (@(posedge mclk) disable iff (rst) // (RL7)
        strapDone && clkEn && !modeCtl_reg.busClockStretchEn
        |=> busClock != $past(busClock))
        else $error("bus clock not free running");

    a_vis_single: assert property (@(posedge mclk) disable iff (rst) // (RL11)
        clkEn && singleChip |=> !visibleDrive && !wideVisible)
        else $error("visibility in single chip mode");

    a_waitoff_special: assert property (@(posedge mclk) disable iff (rst) // (RL14)
        strapDone && clkEn && special
        |=> $stable(modeCtl_reg.extBusStopInWait))
        else $error("wait stop bit changed in special mode");

    a_shutdown_delay: assert property (@(posedge mclk) disable iff (rst) // (RL13)
        $rose(waitArm) ##0 waitHeld |=> ##[0:1] extBusShutdown)
        else $error("bus shutdown not reached after delay");

    a_no_early_stop: assert property (@(posedge mclk) disable iff (rst) // (RL13)
        $rose(waitArm) && clkEn |=> !extBusShutdown ##1 !extBusShutdown)
        else $error("bus shut down before delay");

    a_debug_rom: assert property (@(posedge mclk) disable iff (rst) // (RL20)
        clkEn && debugActive && cpuAddr >= DBG_ROM_LO |=> debugRomSel)
        else $error("debug rom not selected");

    a_debug_start: assert property (@(posedge mclk) disable iff (rst) // (RL19)
        clkEn && strapDone && !debugActive && debugStart |=> debugActive)
        else $error("debug not activated");

endmodule

`default_nettype wire

/* test/host_side_model.sv */
/*
 far side model: external bus activity and the serial debug host.
 assumes one-cycle requests from the bench, launched on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module host_side_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       periphMode,
    input  wire logic [1:0] busKind,
    input  wire logic [1:0] debugReq,
    output logic            extAccess,
    output logic            intAccess,
    output logic            serialDebugCmd,
    output logic            enterDebugInstr,
    output logic            debugExit
);
    // host sends no debug command or enter instruction in peripheral mode, bus conflicts otherwise
    wire logic allowDebug = !periphMode;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {extAccess, intAccess, serialDebugCmd, enterDebugInstr, debugExit} <= 5'h0;
        end else begin
            extAccess       <= (busKind == 2'h1);
            intAccess       <= (busKind == 2'h2);
            serialDebugCmd  <= allowDebug && (debugReq == 2'h1);
            enterDebugInstr <= allowDebug && (debugReq == 2'h2);
            debugExit       <= (debugReq == 2'h3);
        end
    end
endmodule
`default_nettype wire

/* test/tb_top.sv */
/*
 self-checking bench for the operating mode control block.
 assumes op_mode_pkg and host_side_model; APB master lives here.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import op_mode_pkg::*;

    logic           mclk, rst, psel, penable, pwrite, waitMode, busBusy;
    logic           debugEnable, serialAccess, periphMode, pready, pslverr, er, b0;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic [15:0]    cpuAddr;
    logic [1:0]     busKind, debugReq;
    logic           extAccess, intAccess, serialDebugCmd, enterDebugInstr, debugExit;
    logic           busClock, visibleDrive, wideVisible, extBusShutdown, expPortMapped;
    logic           expansionEmuEn, ctlPortMapped, debugActive, debugRomSel, debugRegSel, userTopHidden;
    strap_pins_type strapPins;
    mode_ctl_type   modeCtl;
    int             mismatches;
    int             checks_done;
    // reserved strap 110 comes up as peripheral
    logic [7:0]     resetTable [8] = '{8'h1b, 8'h3b, 8'h5b, 8'h7b, 8'h90, 8'hb0, 8'h5b, 8'hf0};

    operating_mode_control #(.WAIT_DELAY(2)) dut (
        .mclk(mclk), .rst(rst), .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strapPins(strapPins), .extAccess(extAccess), .intAccess(intAccess),
        .waitMode(waitMode), .busBusy(busBusy), .debugEnable(debugEnable),
        .serialDebugCmd(serialDebugCmd), .enterDebugInstr(enterDebugInstr), .debugExit(debugExit),
        .serialAccess(serialAccess), .cpuAddr(cpuAddr), .modeCtl(modeCtl), .busClock(busClock),
        .visibleDrive(visibleDrive), .wideVisible(wideVisible), .extBusShutdown(extBusShutdown),
        .expPortMapped(expPortMapped), .expansionEmuEn(expansionEmuEn),
        .ctlPortMapped(ctlPortMapped), .debugActive(debugActive), .debugRomSel(debugRomSel),
        .debugRegSel(debugRegSel), .userTopHidden(userTopHidden));

    host_side_model host (
        .mclk(mclk), .rst(rst), .periphMode(periphMode), .busKind(busKind), .debugReq(debugReq),
        .extAccess(extAccess), .intAccess(intAccess), .serialDebugCmd(serialDebugCmd),
        .enterDebugInstr(enterDebugInstr), .debugExit(debugExit));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] d);
        apb(1'b1, OFF_MODE_CTL, {24'h0, d});
    endtask

    task automatic rdm(input logic [7:0] exp);
        apb(1'b0, OFF_MODE_CTL, 32'h0);
        chk("mode read", {24'h0, exp}, rd);
        chk("mode port", {24'h0, exp}, {24'h0, modeCtl});
    endtask

    task automatic do_reset(input logic [2:0] pins, input int n);
        strapPins <= pins;
        rst       <= 1'b1;
        repeat (n) @(posedge mclk);
        rst <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask

    task automatic req(input logic [1:0] r);
        debugReq <= r;
        @(posedge mclk);
        debugReq <= 2'h0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic t_reset_table;
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2:0], 3);
            chk("reset value", {24'h0, resetTable[i]}, {24'h0, modeCtl});
            chk("debug at reset", {31'h0, i == 0}, {31'h0, debugActive});
        end
    endtask

    task automatic t_special_single;
        do_reset(3'h0, 3);
        wr(8'h00);
        rdm(8'h0b);
        wr(8'h64);
        rdm(8'h70);
        wr(8'h40);
        rdm(8'h70);
        wr(8'h00);
        rdm(8'h00);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'h0000_0005, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        cpuAddr <= 16'hff20;
        repeat (2) @(posedge mclk);
        chk("rom sel", 32'h1, {31'h0, debugRomSel});
        chk("reg sel", 32'h0, {31'h0, debugRegSel});
        cpuAddr <= 16'hff06;
        repeat (2) @(posedge mclk);
        chk("reg sel", 32'h1, {31'h0, debugRegSel});
        chk("top hidden", 32'h1, {31'h0, userTopHidden});
        serialAccess <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("top via serial", 32'h0, {31'h0, userTopHidden});
        serialAccess <= 1'b0;
        cpuAddr      <= 16'h1000;
        repeat (2) @(posedge mclk);
        chk("low decode", 32'h0, {30'h0, debugRomSel, debugRegSel});
    endtask

    task automatic t_normal_wide;
        do_reset(3'h7, 3);
        wr(8'haf);
        rdm(8'hbf);
        chk("port map", 32'h2, {29'h0, expPortMapped, expansionEmuEn, ctlPortMapped});
        busKind <= 2'h2;
        repeat (3) @(posedge mclk);
        chk("visible", 32'h2, {30'h0, visibleDrive, wideVisible});
        busKind <= 2'h1;
        repeat (3) @(posedge mclk);
        chk("stretched clock", 32'h1, {31'h0, busClock});
        @(posedge mclk);
        chk("stretched clock", 32'h1, {31'h0, busClock});
        busKind  <= 2'h0;
        waitMode <= 1'b1;
        busBusy  <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("shutdown busy", 32'h0, {31'h0, extBusShutdown});
        busBusy <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("shutdown early", 32'h0, {31'h0, extBusShutdown});
        repeat (4) @(posedge mclk);
        chk("shutdown", 32'h1, {31'h0, extBusShutdown});
        waitMode <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("shutdown off", 32'h0, {31'h0, extBusShutdown});
        wr(8'he0);
        rdm(8'hbb);
    endtask

    task automatic t_normal_single;
        do_reset(3'h4, 3);
        wr(8'h8b);
        rdm(8'h8b);
        chk("port map", 32'h5, {29'h0, expPortMapped, expansionEmuEn, ctlPortMapped});
        busKind <= 2'h2;
        repeat (3) @(posedge mclk);
        chk("no visibility", 32'h0, {31'h0, visibleDrive});
        busKind <= 2'h0;
        @(posedge mclk);
        b0 = busClock;
        @(posedge mclk);
        chk("free clock", {31'h0, ~b0}, {31'h0, busClock});
        wr(8'h9b);
        rdm(8'h8b);
        chk("debug idle", 32'h0, {31'h0, debugActive});
        debugEnable <= 1'b1;
        req(2'h1);
        chk("debug serial", 32'h1, {31'h0, debugActive});
        req(2'h3);
        chk("debug exit", 32'h0, {31'h0, debugActive});
        req(2'h2);
        chk("debug instr", 32'h1, {31'h0, debugActive});
        debugEnable <= 1'b0;
    endtask

    task automatic t_periph_narrow;
        do_reset(3'h2, 3);
        periphMode <= 1'b1;
        apb(1'b0, OFF_MODE_CTL, 32'h0);
        chk("mode hidden", 32'h1, {31'h0, er});
        debugEnable <= 1'b1;
        req(2'h1);
        chk("no debug", 32'h0, {31'h0, debugActive});
        debugEnable <= 1'b0;
        periphMode  <= 1'b0;
        do_reset(3'h1, 3);
        busKind <= 2'h2;
        repeat (3) @(posedge mclk);
        chk("wide visible", 32'h3, {30'h0, visibleDrive, wideVisible});
        busKind <= 2'h0;
    endtask

    initial begin
        mismatches   = 0;
        checks_done  = 0;
        rst          = 1'b1;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 12'h0;
        pwdata       = 32'h0;
        strapPins    = 3'h0;
        waitMode     = 1'b0;
        busBusy      = 1'b0;
        debugEnable  = 1'b0;
        serialAccess = 1'b0;
        periphMode   = 1'b0;
        cpuAddr      = 16'h0;
        busKind      = 2'h0;
        debugReq     = 2'h0;
        do_reset(3'h0, 20);
        t_reset_table;
        t_special_single;
        t_normal_wide;
        t_normal_single;
        t_periph_narrow;
        stop_test;
    end

    // whole run needs about two hundred sixty cycles
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        stop_test;
    end
endmodule
`default_nettype wire
